/* design/i2c_ctrl_pkg.sv */
// Purpose: Shared constants and types for the two-wire control register block
// Assumes: Byte-wide special-function register access by the core
// Notes:   Divisors count system clock cycles
package i2c_ctrl_pkg;
    localparam logic [7:0]  CTRL_ADDR      = 8'hdc;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam int          RATE_HI_BIT    = 7;
    localparam int          ENABLE_BIT     = 6;
    localparam int          BEGIN_BIT      = 5;
    localparam int          END_BIT        = 4;
    localparam int          MATCH_BIT      = 3;
    localparam int          ACK_BIT        = 2;
    localparam int          RATE_LO_MSB    = 1;
    localparam logic [10:0] DIV_0          = 11'h020;
    localparam logic [10:0] DIV_1          = 11'h030;
    localparam logic [10:0] DIV_2          = 11'h03c;
    localparam logic [10:0] DIV_3          = 11'h078;
    localparam logic [10:0] DIV_4          = 11'h0f0;
    localparam logic [10:0] DIV_5          = 11'h1e0;
    localparam logic [10:0] DIV_6          = 11'h3c0;
    localparam logic [10:0] DIV_7          = 11'h780;

    // Bus events seen by the engine
    typedef struct packed {
        logic start_seen;
        logic stop_seen;
        logic addr_match;
        logic ack_slot;
    } bus_event_t;

    // Master sequencing states
    typedef enum logic [1:0] {
        M_IDLE  = 2'b00,
        M_START = 2'b01,
        M_RUN   = 2'b10,
        M_STOP  = 2'b11
    } mstate_t;
endpackage

/* design/i2c_control_register_logic.sv */
// Purpose: Control register, SCL divider, start/stop sequencing and acknowledge drive
// Assumes: Shift engine outside reports address match and acknowledge slot timing
// Notes:   SDA and SCL are open-drain; oe high means pulling low
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Master SCL is the system clock divided by 32,48,60,120,240,480,960 or 1920 per rate bits.
// - With the enable bit clear both lines float; setting it enables the engine.
// - Setting the begin request enters master mode and issues START once the bus is free.
// - The begin request clears itself when a START is seen on the bus.
// - A begin request made during interrupt service waits until service ends.
// - Setting the end request in master mode issues a STOP.
// - The end request clears itself when a STOP is seen.
// - An end request made during interrupt service waits until service ends.
// - The match bit sets on an own-address match in slave mode and holds until software clears it.
// - With acknowledge enabled SDA is pulled low in the acknowledge slot after a slave address match or a received byte.
// - With acknowledge disabled SDA is left high in the acknowledge slot.
// - The control register resets to zero.
// - The pending flag sets on any interface event and holds until software clears it.
// - The bus counts as busy from a START until a STOP and gates the begin request.
module i2c_control_register_logic
    import i2c_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    // Register port
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    // Engine events, pending flag, master mode and busy flag
    input  wire logic       i_addr_match,
    input  wire logic       i_byte_rx_done,
    input  wire logic       i_ack_slot,
    input  wire logic       i_irq_event,
    input  wire logic       i_irq_clear,
    output logic            o_irq_pending,
    output logic            o_master_mode,
    output logic            o_line_in_use_flag,
    // Bus pins
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_scl,
    output logic            o_scl_oe,
    output logic            o_sda,
    output logic            o_sda_oe
);
    logic [7:0]  ctrl_q, ctrl_d;
    logic [1:0]  scl_sync_q, sda_sync_q;
    logic        scl_prev_q, sda_prev_q;
    logic        busy_q, busy_d;
    logic        irq_q, irq_d;
    logic        acking_q, acking_d;
    logic [10:0] cnt_q, cnt_d;
    logic        scl_low_q, scl_low_d;
    logic        sda_low_q, sda_low_d;
    logic        master_q, master_d;
    mstate_t     st_q, st_d;
    logic [10:0] divisor;
    bus_event_t  ev;

    // Pin synchronisers and edge history
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end
        else
        begin
            scl_sync_q <= {scl_sync_q[0], i_scl};
            sda_sync_q <= {sda_sync_q[0], i_sda};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // Bus condition detection
    always_comb
    begin
        ev.start_seen = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
        ev.stop_seen  = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
        ev.addr_match = i_addr_match && !master_q;
        ev.ack_slot   = i_ack_slot;
    end

    // Divisor lookup
    always_comb
    begin
        case ({ctrl_q[RATE_HI_BIT], ctrl_q[RATE_LO_MSB:0]})
            3'h0:    divisor = DIV_0;
            3'h1:    divisor = DIV_1;
            3'h2:    divisor = DIV_2;
            3'h3:    divisor = DIV_3;
            3'h4:    divisor = DIV_4;
            3'h5:    divisor = DIV_5;
            3'h6:    divisor = DIV_6;
            default: divisor = DIV_7;
        endcase
    end

    // Register, flags and master sequencer next state
    always_comb
    begin
        ctrl_d    = ctrl_q;
        busy_d    = busy_q;
        irq_d     = irq_q;
        acking_d  = acking_q;
        cnt_d     = cnt_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        master_d  = master_q;
        st_d      = st_q;
        if (i_reg_wr && i_reg_addr == CTRL_ADDR)
            ctrl_d = i_reg_wdata;
        if (ev.start_seen)
            ctrl_d[BEGIN_BIT] = 1'b0;
        if (ev.stop_seen)
            ctrl_d[END_BIT] = 1'b0;
        if (ev.addr_match)
            ctrl_d[MATCH_BIT] = 1'b1;
        // Busy span
        if (ev.start_seen)
            busy_d = 1'b1;
        else if (ev.stop_seen)
            busy_d = 1'b0;
        // Pending flag, set wins over clear
        if (i_irq_event)
            irq_d = 1'b1;
        else if (i_irq_clear)
            irq_d = 1'b0;
        // Acknowledge decision latched at the event
        if (ev.addr_match || i_byte_rx_done)
            acking_d = ctrl_q[ACK_BIT];
        else if (!i_ack_slot)
            acking_d = acking_q;
        // SCL half-period counter
        if (cnt_q >= (divisor >> 1) - 11'h001)
            cnt_d = 11'h000;
        else
            cnt_d = cnt_q + 11'h001;
        case (st_q)
            M_IDLE:
            begin
                scl_low_d = 1'b0;
                sda_low_d = 1'b0;
                if (ctrl_q[ENABLE_BIT] && ctrl_q[BEGIN_BIT] && !busy_q && !irq_q)
                begin
                    master_d = 1'b1;
                    st_d     = M_START;
                    cnt_d    = 11'h000;
                end
            end
            M_START:
            begin
                sda_low_d = 1'b1;
                if (cnt_q == 11'h000 && sda_low_q)
                begin
                    scl_low_d = 1'b1;
                    st_d      = M_RUN;
                end
            end
            M_RUN:
            begin
                if (cnt_q == 11'h000)
                    scl_low_d = !scl_low_q;
                if (ctrl_q[END_BIT] && !irq_q && scl_low_q && cnt_q == 11'h000)
                begin
                    sda_low_d = 1'b1;
                    st_d      = M_STOP;
                end
            end
            M_STOP:
            begin
                if (cnt_q == 11'h000)
                begin
                    if (scl_low_q)
                        scl_low_d = 1'b0;
                    else
                    begin
                        sda_low_d = 1'b0;
                        master_d  = 1'b0;
                        st_d      = M_IDLE;
                    end
                end
            end
            default: st_d = M_IDLE;
        endcase
        if (!ctrl_q[ENABLE_BIT])
        begin
            st_d      = M_IDLE;
            master_d  = 1'b0;
            scl_low_d = 1'b0;
            sda_low_d = 1'b0;
        end
    end

    // State registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_q    <= CTRL_RESET;
            busy_q    <= 1'b0;
            irq_q     <= 1'b0;
            acking_q  <= 1'b0;
            cnt_q     <= 11'h000;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            master_q  <= 1'b0;
            st_q      <= M_IDLE;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            busy_q    <= busy_d;
            irq_q     <= irq_d;
            acking_q  <= acking_d;
            cnt_q     <= cnt_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            master_q  <= master_d;
            st_q      <= st_d;
        end
    end

    // Outputs; pins only pull low, float when disabled
    assign o_reg_rdata        = ctrl_q;
    assign o_irq_pending      = irq_q;
    assign o_master_mode      = master_q;
    assign o_line_in_use_flag = busy_q;
    assign o_scl              = 1'b0;
    assign o_sda              = 1'b0;
    assign o_scl_oe           = ctrl_q[ENABLE_BIT] && scl_low_q;
    assign o_sda_oe           = ctrl_q[ENABLE_BIT]
                                && (sda_low_q || (ev.ack_slot && acking_q));
endmodule

`default_nettype wire

/* testbench/i2c_ctrl_checker.sv */
// Purpose: Port assertions for the control block
// Assumes: Sees the top module ports only
// Notes:   One clock domain
`timescale 1ns/100ps
`default_nettype none
module i2c_ctrl_checker
    import i2c_ctrl_pkg::*;
(
    // Clock, reset and register port
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // Engine events and flags
    input wire logic       i_addr_match,
    input wire logic       i_ack_slot,
    input wire logic       i_irq_event,
    input wire logic       i_irq_clear,
    input wire logic       o_irq_pending,
    input wire logic       o_master_mode,
    input wire logic       o_line_in_use_flag,
    // Pin drives
    input wire logic       o_scl_oe,
    input wire logic       o_sda_oe
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic wr_c = i_reg_wr && i_reg_addr == CTRL_ADDR;
    // Slave match then acknowledge slot
    sequence s_slot(v);
        o_reg_rdata[6] && o_reg_rdata[2] == v && !o_master_mode && i_addr_match ##1 i_ack_slot;
    endsequence
    property p_off; !o_reg_rdata[6] |-> !o_scl_oe && !o_sda_oe; endproperty
    a_off: assert property (p_off) else $error("pins driven while off");
    property p_irq_set; i_irq_event |=> o_irq_pending; endproperty
    a_irq_set: assert property (p_irq_set) else $error("pending not set");
    property p_irq_hold; o_irq_pending && !i_irq_clear |=> o_irq_pending; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("pending lost");
    property p_match; i_addr_match && o_reg_rdata[6] && !o_master_mode |=> o_reg_rdata[3];
    endproperty
    a_match: assert property (p_match) else $error("match bit not set");
    property p_match_hold; o_reg_rdata[3] && !wr_c |=> o_reg_rdata[3]; endproperty
    a_match_hold: assert property (p_match_hold) else $error("match bit lost");
    property p_wr; wr_c |=> {o_reg_rdata[7:6], o_reg_rdata[2:0]}
        == $past({i_reg_wdata[7:6], i_reg_wdata[2:0]}); endproperty
    a_wr: assert property (p_wr) else $error("write not taken");
    property p_defer; (o_irq_pending || o_line_in_use_flag) && !o_master_mode |=> !o_master_mode;
    endproperty
    a_defer: assert property (p_defer) else $error("start not deferred");
    property p_ack; s_slot(1'b1) |-> o_sda_oe; endproperty
    a_ack: assert property (p_ack) else $error("no acknowledge");
    property p_nack; s_slot(1'b0) |-> !o_sda_oe; endproperty
    a_nack: assert property (p_nack) else $error("unwanted acknowledge");
endmodule
`default_nettype wire

/* testbench/i2c_bus_peer.sv */
// Purpose: Other party on the two-wire bus
// Assumes: Open-drain lines with pull-ups
// Notes:   Peer pulls are commanded by the bench
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_peer (
    // Pull requests
    input  wire logic i_dut_scl_oe,
    input  wire logic i_dut_sda_oe,
    input  wire logic i_peer_scl_low,
    input  wire logic i_peer_sda_low,
    // Resolved wires
    output logic      o_scl,
    output logic      o_sda
);
    // Wired-AND; peer SDA pulls frame START and STOP
    assign o_scl = !(i_dut_scl_oe || i_peer_scl_low);
    assign o_sda = !(i_dut_sda_oe || i_peer_sda_low);
endmodule
`default_nettype wire

/* testbench/i2c_control_register_logic_tb.sv */
// Purpose: Self-checking bench for the control block
// Assumes: Inputs change on the falling edge
// Notes:   Expected register held in an integer model
`timescale 1ns/100ps
`default_nettype none
module i2c_control_register_logic_tb import i2c_ctrl_pkg::*;;
    logic       clk = 0, rst_n = 0, wr = 0, am = 0, brx = 0, slot = 0, iev = 0, icl = 0;
    logic       psda = 0, pscl = 0, scl, sda, scl_oe, sda_oe, pend, mst, busy;
    logic       scl_o, sda_o;
    logic [7:0] addr = CTRL_ADDR, wd = 0, rd;
    int         err_count = 0, compares = 0, model = 0, n, per, r;
    int         div_tab [8] = '{32, 48, 60, 120, 240, 480, 960, 1920};
    // Clock
    initial forever #10 clk = !clk;
    i2c_control_register_logic dut_u (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_wdata(wd), .o_reg_rdata(rd), .i_addr_match(am), .i_byte_rx_done(brx),
        .i_ack_slot(slot), .i_irq_event(iev), .i_irq_clear(icl), .o_irq_pending(pend),
        .o_master_mode(mst), .o_line_in_use_flag(busy), .i_scl(scl), .i_sda(sda),
        .o_scl(scl_o), .o_scl_oe(scl_oe), .o_sda(sda_o), .o_sda_oe(sda_oe));
    i2c_bus_peer peer_u (.i_dut_scl_oe(scl_oe), .i_dut_sda_oe(sda_oe),
        .i_peer_scl_low(pscl), .i_peer_sda_low(psda), .o_scl(scl), .o_sda(sda));
    task automatic check(input string nm, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk) s = 0;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk) {addr, wr} = {CTRL_ADDR, 1'b0};
        if (a == CTRL_ADDR) model = d;
        @(negedge clk);
    endtask
    // Stop request, optionally held back by a pending interrupt
    task automatic stop_bus(input logic [7:0] c, input bit hold);
        if (hold) pulse(iev);
        wr_reg(CTRL_ADDR, c);
        if (hold)
        begin
            repeat (100) @(negedge clk);
            check("end held", 1, rd[4]);
            pulse(icl);
            check("pending cleared", 0, pend);
        end
        for (n = 0; n < 8000 && (busy || rd[4]); n++) @(negedge clk);
        check("end done", 0, {rd[4], busy});
    endtask
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Watchdog at 50k cycles, several times the full sweep
    initial
    begin
        #1000000;
        err_count++;
        tally_and_finish;
    end
    initial
    begin
        r = $urandom(32'h9da6);
        repeat (3) @(negedge clk);
        rst_n = 1;
        check("reset value", CTRL_RESET, rd);
        check("reset pins", 0, {scl_oe, sda_oe});
        check("pin levels", 0, {scl_o, sda_o});
        wr_reg(8'hdd, 8'hff);
        check("unmapped", model, rd);
        // Every rate: start, one SCL period, stop; divide-by-32 gets the same run state and stop checks
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(CTRL_ADDR, {k[2], 2'b11, 3'b000, k[1:0]});
            check("rate bits", k, {rd[7], rd[1:0]});
            for (n = 0; n < 4000 && !scl_oe; n++) @(negedge clk);
            for (n = 0; n < 4000 && scl_oe; n++) @(negedge clk);
            for (per = n; per < 4000 && !scl_oe; per++) @(negedge clk);
            check("scl period", div_tab[k], per);
            check("run state", 3'b011, {rd[5], mst, busy});
            stop_bus({k[2], 3'b101, 2'b00, k[1:0]}, 0);
        end
        // Request waits on a busy bus and on a pending interrupt
        psda = 1;
        repeat (6) @(negedge clk);
        check("peer busy", 1, busy);
        wr_reg(CTRL_ADDR, 8'h60);
        repeat (20) @(negedge clk);
        check("start held busy", 0, {mst, sda_oe});
        pulse(iev);
        check("pending set", 1, pend);
        psda = 0;
        repeat (20) @(negedge clk);
        check("start held pending", 0, {mst, sda_oe});
        pulse(icl);
        for (n = 0; n < 100 && !sda_oe; n++) @(negedge clk);
        check("start issued", 3, {mst, sda_oe});
        stop_bus(8'h50, 1);
        // Acknowledge slot after match or received byte, acknowledge off and on
        for (int k = 0; k < 4; k++)
        begin
            r = $urandom;
            wr_reg(CTRL_ADDR, {r[7], 4'b1000, k[0], r[1:0]});
            check("ctrl value", model, rd);
            // Peer holds SCL low so the slot frames no bus condition
            am = !k[1];
            brx = k[1];
            pscl = 1;
            @(negedge clk);
            {am, brx, slot} = 3'b001;
            #5 check("ack drive", k[0], sda_oe);
            check("match bit", !k[1], rd[3]);
            @(negedge clk) {slot, pscl} = 2'b00;
        end
        wr_reg(CTRL_ADDR, 8'h00);
        check("disabled", 0, {scl_oe, sda_oe, rd});
        tally_and_finish;
    end
endmodule
bind i2c_control_register_logic i2c_ctrl_checker chk_u (.i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n), .i_reg_wr(i_reg_wr), .i_addr_match(i_addr_match),
    .i_ack_slot(i_ack_slot), .i_irq_event(i_irq_event), .i_irq_clear(i_irq_clear),
    .o_irq_pending(o_irq_pending), .o_master_mode(o_master_mode),
    .o_line_in_use_flag(o_line_in_use_flag), .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata));
`default_nettype wire
